// ===== logic/ict_pkg.sv
// Purpose: Shared types and constants for the instruction cycle timing model.
// Assumes: One processor clock; requests arrive already decoded.
// Notes:   Counts are clock periods; a bus cycle is a fixed number of clocks.
package ict_pkg;

    // Widths of the reported counts
    localparam int CLK_W = 8;
    localparam int RD_W  = 4;
    localparam int WR_W  = 3;

    // Fixed timing figures, in clock periods
    localparam logic [7:0] BUS_CYCLE_CLKS      = 8'h04;
    localparam logic [7:0] LONG_REG_BOOST_CLKS = 8'h08;
    localparam logic [7:0] SIGNED_DIV_CLKS     = 8'h9e;  // 158
    localparam logic [7:0] UNSIGNED_DIV_CLKS   = 8'h8c;  // 140
    localparam logic [7:0] MUL_BASE_CLKS       = 8'h26;  // 38
    localparam logic [7:0] SET_TRUE_CLKS       = 8'h06;
    localparam logic [7:0] TEST_SET_MEM_CLKS   = 8'h0e;  // 14

    typedef enum logic [4:0] {
        ict_op_add, ict_op_sub, ict_op_and, ict_op_or, ict_op_compare,
        ict_op_exclusive_or, ict_op_signed_divide, ict_op_unsigned_divide,
        ict_op_signed_multiply, ict_op_unsigned_multiply,
        ict_op_add_immediate, ict_op_subtract_immediate, ict_op_and_immediate,
        ict_op_or_immediate, ict_op_exclusive_or_immediate, ict_op_compare_immediate,
        ict_op_add_quick, ict_op_subtract_quick, ict_op_move_quick,
        ict_op_clear, ict_op_negate, ict_op_negate_extend, ict_op_complement,
        ict_op_decimal_negate, ict_op_set_condition, ict_op_test_and_set_op,
        ict_op_test
    } ict_op_t;

    typedef enum logic [1:0] {
        ict_size_byte = 2'h0,
        ict_size_word = 2'h1,
        ict_size_long = 2'h2
    } ict_size_t;

    // Where the result goes: address register, data register, memory
    typedef enum logic [1:0] {
        ict_form_to_areg = 2'h0,
        ict_form_to_dreg = 2'h1,
        ict_form_to_mem  = 2'h2
    } ict_form_t;

    typedef enum logic [3:0] {
        ict_ea_dreg, ict_ea_areg, ict_ea_ind, ict_ea_post_inc, ict_ea_pre_dec,
        ict_ea_disp, ict_ea_index, ict_ea_abs_short, ict_ea_abs_long,
        ict_ea_pc_disp, ict_ea_pc_index, ict_ea_immediate
    } ict_ea_t;

    // Sequencer phases, Gray coded along idle-read-internal-write
    typedef enum logic [1:0] {
        ict_ph_idle     = 2'b00,
        ict_ph_read     = 2'b01,
        ict_ph_internal = 2'b11,
        ict_ph_write    = 2'b10
    } ict_phase_t;

    typedef struct packed {
        ict_op_t    op;
        ict_size_t  size;
        ict_form_t  form;
        ict_ea_t    ea;
        logic       cond_true;
        logic [15:0] src;
    } ict_req_t;

    typedef struct packed {
        logic             illegal;
        logic [CLK_W-1:0] clocks;
        logic [RD_W-1:0]  reads;
        logic [WR_W-1:0]  writes;
    } ict_timing_t;

endpackage : ict_pkg

// ===== logic/ict_sequencer.sv
// Purpose: Decode an instruction's timing and walk its bus and idle clocks.
// Assumes: Request fields are stable while i_req_valid is high.
// Notes:   Reads come first, then internal time, then writes.

// Behaviour
// - Counts cover operation, store and next fetch.
// - Plus entries add address calculation cost.
// - Long to register six, eight if register/immediate, except compare which stays six.
// - Divides at most 158 and 140 clocks.
// - Multiply 38 plus two per counted bit.
// - Signed multiply counts bit pairs of 17 bits.
// - Exclusive-or to register needs data register source.
// - Add/and/or/sub register and memory base counts.
// - Immediate forms include immediate word fetches.
// - Single operand register and test-and-set counts.
// - Each bus cycle four clocks, rest internal.
module ict_sequencer (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_req_valid,
    input  wire ict_pkg::ict_req_t    i_req,
    output logic                      o_req_ready,
    output logic                      o_result_valid,
    output ict_pkg::ict_timing_t      o_result,
    output logic                      o_bus_read,
    output logic                      o_bus_write,
    output logic                      o_done
);

    // Address calculation cost: clocks in [11:4], reads in [3:0]
    function automatic logic [11:0] ea_cost(input ict_pkg::ict_ea_t ea, input logic lng);
        logic [7:0] c;
        logic [3:0] r;
        c = 8'h00;
        r = 4'h0;
        case (ea)
            ict_pkg::ict_ea_ind, ict_pkg::ict_ea_post_inc,
            ict_pkg::ict_ea_immediate: begin c = 8'h04; r = 4'h1; end
            ict_pkg::ict_ea_pre_dec: begin c = 8'h06; r = 4'h1; end
            ict_pkg::ict_ea_disp, ict_pkg::ict_ea_abs_short,
            ict_pkg::ict_ea_pc_disp: begin c = 8'h08; r = 4'h2; end
            ict_pkg::ict_ea_index, ict_pkg::ict_ea_pc_index: begin c = 8'h0a; r = 4'h2; end
            ict_pkg::ict_ea_abs_long: begin c = 8'h0c; r = 4'h3; end
            default: begin c = 8'h00; r = 4'h0; end
        endcase
        // Long operands need one more word fetched
        if (lng && r != 4'h0) begin
            c = c + ict_pkg::BUS_CYCLE_CLKS;
            r = r + 4'h1;
        end
        return {c, r};
    endfunction : ea_cost

    function automatic ict_pkg::ict_timing_t calc_timing(input ict_pkg::ict_req_t q);
        ict_pkg::ict_timing_t t;
        logic        lng;
        logic        reg_ea;
        logic        ea_plus;
        logic        boost;
        logic        word_ea;
        logic [11:0] ec;
        logic [4:0]  n;
        t       = '0;
        lng     = (q.size == ict_pkg::ict_size_long);
        reg_ea  = (q.ea == ict_pkg::ict_ea_dreg) || (q.ea == ict_pkg::ict_ea_areg)
                  || (q.ea == ict_pkg::ict_ea_immediate);
        ea_plus = 1'b1;
        boost   = 1'b0;
        word_ea = 1'b0;
        n       = 5'h00;
        ec      = 12'h000;
        case (q.op)
            ict_pkg::ict_op_add, ict_pkg::ict_op_sub, ict_pkg::ict_op_and,
            ict_pkg::ict_op_or, ict_pkg::ict_op_compare, ict_pkg::ict_op_exclusive_or: begin
                case (q.form)
                    ict_pkg::ict_form_to_areg: begin
                        // Address destination: add/sub/compare, word or long
                        if (q.size == ict_pkg::ict_size_byte || q.op == ict_pkg::ict_op_and
                            || q.op == ict_pkg::ict_op_or
                            || q.op == ict_pkg::ict_op_exclusive_or) begin
                            t.illegal = 1'b1;
                        end else if (q.op == ict_pkg::ict_op_compare) begin
                            t.clocks = 8'h06;
                        end else begin
                            t.clocks = lng ? 8'h06 : 8'h08;
                            boost    = lng;
                        end
                        t.reads = 4'h1;
                    end
                    ict_pkg::ict_form_to_dreg: begin
                        t.reads = 4'h1;
                        if (q.op == ict_pkg::ict_op_exclusive_or) begin
                            t.illegal = (q.ea != ict_pkg::ict_ea_dreg);
                            t.clocks  = lng ? 8'h08 : 8'h04;
                            ea_plus   = 1'b0;
                        end else begin
                            t.clocks = lng ? 8'h06 : 8'h04;
                            boost    = lng && (q.op != ict_pkg::ict_op_compare);
                        end
                    end
                    default: begin
                        // Result stored to memory: one write per word
                        t.illegal = (q.op == ict_pkg::ict_op_compare) || reg_ea;
                        t.clocks  = lng ? 8'h0c : 8'h08;
                        t.reads   = 4'h1;
                        t.writes  = lng ? 3'h2 : 3'h1;
                    end
                endcase
            end
            ict_pkg::ict_op_signed_divide, ict_pkg::ict_op_unsigned_divide: begin
                // Worst-case figure; best case lies within ten percent of it
                t.illegal = (q.form != ict_pkg::ict_form_to_dreg);
                t.clocks  = (q.op == ict_pkg::ict_op_signed_divide) ?
                            ict_pkg::SIGNED_DIV_CLKS : ict_pkg::UNSIGNED_DIV_CLKS;
                t.reads   = 4'h1;
                word_ea   = 1'b1;
            end
            ict_pkg::ict_op_signed_multiply, ict_pkg::ict_op_unsigned_multiply: begin
                if (q.op == ict_pkg::ict_op_unsigned_multiply) begin
                    n = 5'($countones(q.src));
                end else begin
                    n = 5'($countones(q.src ^ {q.src[14:0], 1'b0}));
                end
                t.illegal = (q.form != ict_pkg::ict_form_to_dreg);
                t.clocks  = ict_pkg::MUL_BASE_CLKS + {2'b00, n, 1'b0};
                t.reads   = 4'h1;
                word_ea   = 1'b1;
            end
            ict_pkg::ict_op_add_immediate, ict_pkg::ict_op_subtract_immediate,
            ict_pkg::ict_op_and_immediate, ict_pkg::ict_op_or_immediate,
            ict_pkg::ict_op_exclusive_or_immediate, ict_pkg::ict_op_compare_immediate: begin
                // Immediate words are fetched as part of the count
                t.reads = lng ? 4'h3 : 4'h2;
                case (q.form)
                    ict_pkg::ict_form_to_dreg: begin
                        ea_plus  = 1'b0;
                        t.clocks = !lng ? 8'h08 :
                                   (q.op == ict_pkg::ict_op_and_immediate ||
                                    q.op == ict_pkg::ict_op_compare_immediate) ? 8'h0e
                                   : 8'h10;
                    end
                    ict_pkg::ict_form_to_mem: begin
                        t.illegal = reg_ea;
                        if (q.op == ict_pkg::ict_op_compare_immediate) begin
                            t.clocks = lng ? 8'h0c : 8'h08;
                        end else begin
                            t.clocks = lng ? 8'h14 : 8'h0c;
                            t.writes = lng ? 3'h2 : 3'h1;
                        end
                    end
                    default: t.illegal = 1'b1;
                endcase
            end
            ict_pkg::ict_op_add_quick, ict_pkg::ict_op_subtract_quick,
            ict_pkg::ict_op_move_quick: begin
                t.reads = 4'h1;
                if (q.op == ict_pkg::ict_op_move_quick) begin
                    t.illegal = (q.form != ict_pkg::ict_form_to_dreg);
                    t.clocks  = 8'h04;
                    ea_plus   = 1'b0;
                end else if (q.form == ict_pkg::ict_form_to_mem) begin
                    t.illegal = reg_ea;
                    t.clocks  = lng ? 8'h0c : 8'h08;
                    t.writes  = lng ? 3'h2 : 3'h1;
                end else begin
                    ea_plus   = 1'b0;
                    t.illegal = (q.form == ict_pkg::ict_form_to_areg)
                                && (q.size == ict_pkg::ict_size_byte);
                    t.clocks  = (lng || (q.form == ict_pkg::ict_form_to_areg &&
                                 q.op == ict_pkg::ict_op_subtract_quick)) ? 8'h08 : 8'h04;
                end
            end
            ict_pkg::ict_op_clear, ict_pkg::ict_op_negate, ict_pkg::ict_op_negate_extend,
            ict_pkg::ict_op_complement, ict_pkg::ict_op_decimal_negate,
            ict_pkg::ict_op_set_condition, ict_pkg::ict_op_test_and_set_op,
            ict_pkg::ict_op_test: begin
                t.reads = 4'h1;
                if (q.form == ict_pkg::ict_form_to_dreg) begin
                    ea_plus  = 1'b0;
                    t.clocks = (q.op == ict_pkg::ict_op_decimal_negate
                                || (q.op == ict_pkg::ict_op_set_condition && q.cond_true)
                                || (lng && q.op != ict_pkg::ict_op_test))
                               ? ict_pkg::SET_TRUE_CLKS : 8'h04;
                end else if (q.form == ict_pkg::ict_form_to_mem) begin
                    t.illegal = reg_ea;
                    if (q.op == ict_pkg::ict_op_test_and_set_op) begin
                        t.clocks = ict_pkg::TEST_SET_MEM_CLKS;
                        t.reads  = 4'h2;
                        t.writes = 3'h1;
                    end else if (q.op == ict_pkg::ict_op_test) begin
                        t.clocks = 8'h04;
                    end else begin
                        t.clocks = (lng && q.op != ict_pkg::ict_op_decimal_negate
                                    && q.op != ict_pkg::ict_op_set_condition) ? 8'h0c : 8'h08;
                        t.writes = (t.clocks == 8'h0c) ? 3'h2 : 3'h1;
                    end
                end else begin
                    t.illegal = 1'b1;
                end
            end
            default: t.illegal = 1'b1;
        endcase
        // Register direct or immediate source raises the long base time
        if (boost && reg_ea) begin
            t.clocks = ict_pkg::LONG_REG_BOOST_CLKS;
        end
        // Address calculation clocks and reads summed on top
        if (ea_plus) begin
            ec       = ea_cost(q.ea, lng && !word_ea);
            t.clocks = t.clocks + ec[11:4];
            t.reads  = t.reads + ec[3:0];
        end
        return t;
    endfunction : calc_timing

    ict_pkg::ict_phase_t  st_q;
    ict_pkg::ict_phase_t  st_d;
    logic [7:0]           cnt_q;
    logic [7:0]           cnt_d;
    logic [7:0]           int_len_q;
    logic [7:0]           wr_len_q;
    logic                 acc;
    ict_pkg::ict_timing_t calc;
    logic [7:0]           rd_len;
    logic [7:0]           wr_len;

    assign acc    = i_req_valid && o_req_ready;
    assign calc   = calc_timing(i_req);
    assign rd_len = {2'b00, calc.reads, 2'b00};
    assign wr_len = {3'b000, calc.writes, 2'b00};

    // Next phase: every legal instruction fetches, so reads always lead
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q - 8'h01;
        unique case (st_q)
            ict_pkg::ict_ph_idle: begin
                cnt_d = cnt_q;
                if (acc && !calc.illegal) begin
                    st_d  = ict_pkg::ict_ph_read;
                    cnt_d = rd_len - 8'h01;
                end
            end
            ict_pkg::ict_ph_read: begin
                if (cnt_q == 8'h00) begin
                    // Clocks not spent on the bus are bus-idle internal time
                    if (int_len_q != 8'h00) begin
                        st_d  = ict_pkg::ict_ph_internal;
                        cnt_d = int_len_q - 8'h01;
                    end else if (wr_len_q != 8'h00) begin
                        st_d  = ict_pkg::ict_ph_write;
                        cnt_d = wr_len_q - 8'h01;
                    end else begin
                        st_d = ict_pkg::ict_ph_idle;
                    end
                end
            end
            ict_pkg::ict_ph_internal: begin
                if (cnt_q == 8'h00) begin
                    st_d  = (wr_len_q != 8'h00) ? ict_pkg::ict_ph_write : ict_pkg::ict_ph_idle;
                    cnt_d = wr_len_q - 8'h01;
                end
            end
            ict_pkg::ict_ph_write: begin
                if (cnt_q == 8'h00) begin
                    st_d = ict_pkg::ict_ph_idle;
                end
            end
        endcase
    end

    // Phase state and its bus-facing outputs
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q        <= ict_pkg::ict_ph_idle;
            cnt_q       <= 8'h00;
            o_req_ready <= 1'b1;
            o_bus_read  <= 1'b0;
            o_bus_write <= 1'b0;
            o_done      <= 1'b0;
        end else begin
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            o_req_ready <= (st_d == ict_pkg::ict_ph_idle);
            o_bus_read  <= (st_d == ict_pkg::ict_ph_read);
            o_bus_write <= (st_d == ict_pkg::ict_ph_write);
            o_done      <= (st_q != ict_pkg::ict_ph_idle) && (st_d == ict_pkg::ict_ph_idle);
        end
    end

    // Reported timing, captured once per accepted request
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_result_valid <= 1'b0;
            o_result       <= '0;
            int_len_q      <= 8'h00;
            wr_len_q       <= 8'h00;
        end else begin
            o_result_valid <= acc;
            if (acc) begin
                o_result  <= calc;
                int_len_q <= calc.clocks - rd_len - wr_len;
                wr_len_q  <= wr_len;
            end
        end
    end

    // Cycle tallies that only the checks below read
    logic [7:0]        busy_cnt_q;
    logic [7:0]        rd_cnt_q;
    logic [7:0]        wr_cnt_q;
    ict_pkg::ict_req_t req_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_cnt_q <= 8'h00;
            rd_cnt_q   <= 8'h00;
            wr_cnt_q   <= 8'h00;
            req_q      <= '0;
        end else if (acc) begin
            busy_cnt_q <= 8'h00;
            rd_cnt_q   <= 8'h00;
            wr_cnt_q   <= 8'h00;
            req_q      <= i_req;
        end else begin
            busy_cnt_q <= busy_cnt_q + {7'h00, st_q != ict_pkg::ict_ph_idle};
            rd_cnt_q   <= rd_cnt_q + {7'h00, o_bus_read};
            wr_cnt_q   <= wr_cnt_q + {7'h00, o_bus_write};
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_read_start;
        $rose(o_bus_read);
    endsequence
    sequence s_bus_cycle;
        o_bus_read [*4];
    endsequence

    AST_TOTAL_CLOCKS: assert property (o_done |-> busy_cnt_q == o_result.clocks)
        else $error("busy time differs from reported clocks");
    AST_READ_TIME: assert property (o_done
        |-> rd_cnt_q == {2'b00, o_result.reads, 2'b00})
        else $error("read time is not four clocks per read");
    AST_WRITE_TIME: assert property (o_done
        |-> wr_cnt_q == {3'b000, o_result.writes, 2'b00})
        else $error("write time is not four clocks per write");
    AST_READ_BLOCK: assert property (s_read_start |-> s_bus_cycle)
        else $error("read phase shorter than one bus cycle");
    AST_XOR_SOURCE: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_exclusive_or
        && req_q.form == ict_pkg::ict_form_to_dreg
        |-> o_result.illegal == (req_q.ea != ict_pkg::ict_ea_dreg)
        && o_result.clocks == ((req_q.size == ict_pkg::ict_size_long) ? 8'h08 : 8'h04))
        else $error("exclusive-or source check wrong");
    AST_LONG_BOOST: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_add
        && req_q.form == ict_pkg::ict_form_to_dreg && req_q.size == ict_pkg::ict_size_long
        && req_q.ea == ict_pkg::ict_ea_dreg |-> o_result.clocks == 8'h08)
        else $error("long register base not raised to eight");
    AST_DIV_REG: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_signed_divide && req_q.ea == ict_pkg::ict_ea_dreg
        |-> o_result.clocks == 8'h9e && o_result.reads == 4'h1)
        else $error("signed divide count wrong");
    AST_MUL_BITS: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_unsigned_multiply && req_q.ea == ict_pkg::ict_ea_dreg
        |-> o_result.clocks == 8'(38 + 2 * $countones(req_q.src)))
        else $error("unsigned multiply count wrong");
    AST_MUL_WORST: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_signed_multiply && req_q.ea == ict_pkg::ict_ea_dreg
        && req_q.src == 16'h5555 |-> o_result.clocks == 8'h46)
        else $error("signed multiply worst case is not seventy");
    AST_TAS_MEM: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_test_and_set_op && req_q.size == ict_pkg::ict_size_byte
        && req_q.form == ict_pkg::ict_form_to_mem && req_q.ea == ict_pkg::ict_ea_ind
        |-> o_result.clocks == 8'h12 && o_result.reads == 4'h3 && o_result.writes == 3'h1)
        else $error("test-and-set memory count wrong");
    AST_IMM_LONG: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_add_immediate && req_q.form == ict_pkg::ict_form_to_dreg
        && req_q.size == ict_pkg::ict_size_long
        |-> o_result.clocks == 8'h10 && o_result.reads == 4'h3)
        else $error("long immediate count wrong");
    AST_MEM_LONG: assert property (o_result_valid
        && req_q.op == ict_pkg::ict_op_add
        && req_q.form == ict_pkg::ict_form_to_mem && req_q.size == ict_pkg::ict_size_long
        && req_q.ea == ict_pkg::ict_ea_ind
        |-> o_result.clocks == 8'h14 && o_result.writes == 3'h2)
        else $error("long memory add count wrong");

endmodule : ict_sequencer

// ===== dv/ict_bus_mem.sv
// Purpose: Far-side bus model that tallies read, write and busy clocks per instruction.
// Assumes: Strobes are levels that stand for whole bus cycles.
// Notes:   Tallies restart at each result pulse so the bench can compare them.
module ict_bus_mem (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_bus_read,
    input  wire logic       i_bus_write,
    input  wire logic       i_result_valid,
    input  wire logic       i_done,
    output logic [7:0]      o_rd_clks,
    output logic [7:0]      o_wr_clks,
    output logic [7:0]      o_span
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy_q;
    // Count strobe clocks between the result pulse and done; idle clocks are internal time
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {busy_q, o_rd_clks, o_wr_clks, o_span} <= '0;
        end else if (i_result_valid) begin
            busy_q    <= 1'b1;
            o_span    <= 8'h01;
            o_rd_clks <= {7'h00, i_bus_read};
            o_wr_clks <= {7'h00, i_bus_write};
        end else if (busy_q && !i_done) begin
            o_span    <= o_span + 8'h01;
            o_rd_clks <= o_rd_clks + {7'h00, i_bus_read};
            o_wr_clks <= o_wr_clks + {7'h00, i_bus_write};
        end else if (i_done) begin
            busy_q <= 1'b0;
        end
    end
endmodule : ict_bus_mem

// ===== dv/instruction_cycle_timing_tb.sv
// Purpose: Self-checking bench for the instruction timing sequencer.
// Assumes: Inputs change on the falling edge; one request at a time.
// Notes:   Bus clock tallies come from the far-side model, not the design.
module instruction_cycle_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0;
    ict_pkg::ict_req_t    i_req = '0;
    ict_pkg::ict_timing_t o_result;
    logic o_req_ready, o_result_valid, o_bus_read, o_bus_write, o_done;
    logic [7:0] rd_clks, wr_clks, span;
    int err_total = 0, tests_run = 0;

    always #25 i_clock = ~i_clock;

    ict_sequencer ict_sequencer_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
        .o_result_valid(o_result_valid), .o_result(o_result),
        .o_bus_read(o_bus_read), .o_bus_write(o_bus_write), .o_done(o_done));
    ict_bus_mem ict_bus_mem_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_bus_read(o_bus_read), .i_bus_write(o_bus_write),
        .i_result_valid(o_result_valid), .i_done(o_done),
        .o_rd_clks(rd_clks), .o_wr_clks(wr_clks), .o_span(span));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Issue one request and judge the report, the bus tallies and the busy span
    task automatic run(input ict_pkg::ict_op_t op, input ict_pkg::ict_size_t sz,
                       input ict_pkg::ict_form_t fm, input ict_pkg::ict_ea_t ea,
                       input logic [15:0] src, input logic [15:0] exp);
        int n;
        ict_pkg::ict_timing_t e;
        e = ict_pkg::ict_timing_t'(exp);
        i_req       = '{op, sz, fm, ea, 1'b0, src};
        i_req_valid = 1'b1;
        @(negedge i_clock);
        i_req_valid = 1'b0;
        chk(16'(o_result_valid), 16'h0001);
        chk(16'(o_req_ready), 16'(e.illegal));
        if (e.illegal) begin
            chk(16'(o_result.illegal), 16'h0001);
            return;
        end
        chk(16'(o_result), exp);
        n = 0;
        while (o_done !== 1'b1 && n < 300) begin
            @(negedge i_clock);
            n++;
        end
        // A missing done pulse counts as a mismatch here
        chk(16'(o_done), 16'h0001);
        chk(16'(o_req_ready), 16'h0001);
        chk(16'(rd_clks), 16'({e.reads, 2'b00}));
        chk(16'(wr_clks), 16'({e.writes, 1'b0, 1'b0}));
        chk(16'(span), 16'(e.clocks));
    endtask : run

    // Expected report packed as {illegal, clocks, reads, writes}
    function automatic logic [15:0] tm(input logic [7:0] c, input logic [3:0] r,
                                       input logic [2:0] w);
        return {1'b0, c, r, w};
    endfunction : tm

    task automatic t_two_operand;
        run(ict_pkg::ict_op_add, ict_pkg::ict_size_word, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h04, 4'h1, 3'h0));
        run(ict_pkg::ict_op_add, ict_pkg::ict_size_word, ict_pkg::ict_form_to_areg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h08, 4'h1, 3'h0));
        run(ict_pkg::ict_op_compare, ict_pkg::ict_size_long, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h06, 4'h1, 3'h0));
        run(ict_pkg::ict_op_or, ict_pkg::ict_size_long, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h08, 4'h1, 3'h0));
        run(ict_pkg::ict_op_sub, ict_pkg::ict_size_long, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_ind, 16'h0000, tm(8'h0e, 4'h3, 3'h0));
        run(ict_pkg::ict_op_and, ict_pkg::ict_size_long, ict_pkg::ict_form_to_mem,
            ict_pkg::ict_ea_ind, 16'h0000, tm(8'h14, 4'h3, 3'h2));
    endtask : t_two_operand

    task automatic t_xor;
        run(ict_pkg::ict_op_exclusive_or, ict_pkg::ict_size_word, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_areg, 16'h0000, 16'h8000);
        run(ict_pkg::ict_op_exclusive_or, ict_pkg::ict_size_long, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h08, 4'h1, 3'h0));
    endtask : t_xor

    task automatic t_mul_div;
        run(ict_pkg::ict_op_unsigned_multiply, ict_pkg::ict_size_word, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'hffff, tm(8'h46, 4'h1, 3'h0));
        run(ict_pkg::ict_op_signed_multiply, ict_pkg::ict_size_word, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0001, tm(8'h2a, 4'h1, 3'h0));
        run(ict_pkg::ict_op_signed_multiply, ict_pkg::ict_size_word, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h5555, tm(8'h46, 4'h1, 3'h0));
        run(ict_pkg::ict_op_signed_divide, ict_pkg::ict_size_word, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h9e, 4'h1, 3'h0));
        run(ict_pkg::ict_op_unsigned_divide, ict_pkg::ict_size_word, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h8c, 4'h1, 3'h0));
    endtask : t_mul_div

    task automatic t_imm_single;
        run(ict_pkg::ict_op_add_immediate, ict_pkg::ict_size_long, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h10, 4'h3, 3'h0));
        run(ict_pkg::ict_op_subtract_immediate, ict_pkg::ict_size_long, ict_pkg::ict_form_to_mem,
            ict_pkg::ict_ea_ind, 16'h0000, tm(8'h1c, 4'h5, 3'h2));
        run(ict_pkg::ict_op_test_and_set_op, ict_pkg::ict_size_byte, ict_pkg::ict_form_to_mem,
            ict_pkg::ict_ea_ind, 16'h0000, tm(8'h12, 4'h3, 3'h1));
        run(ict_pkg::ict_op_negate, ict_pkg::ict_size_long, ict_pkg::ict_form_to_dreg,
            ict_pkg::ict_ea_dreg, 16'h0000, tm(8'h06, 4'h1, 3'h0));
    endtask : t_imm_single

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Watchdog: the whole list takes well under a thousand clocks
    initial begin
        #(20000 * 50);
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (4) @(negedge i_clock);
        i_rst_n = 1'b1;
        chk(16'(o_req_ready), 16'h0001);
        t_two_operand();
        t_xor();
        t_mul_div();
        t_imm_single();
        give_verdict();
    end
endmodule : instruction_cycle_timing_tb
